// ### core/arfc_regs.svh
// Register map, field positions, reset values and rates of the result formatter
`ifndef ARFC_REGS_SVH
`define ARFC_REGS_SVH

// ----------------------------------------------------------------------------
// Register offsets (3-bit word address)
// ----------------------------------------------------------------------------
`define ARFC_ADDR_W          3
`define ARFC_OFS_CONV_CTRL   3'h0
`define ARFC_OFS_RES_HIGH    3'h1
`define ARFC_OFS_RES_LOW     3'h2
`define ARFC_OFS_CLK_FMT     3'h3
`define ARFC_OFS_IRQ_STAT    3'h4
`define ARFC_OFS_IRQ_CLR     3'h5
`define ARFC_OFS_IRQ_EN      3'h6

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define ARFC_CTRL_DONE_BIT   7
`define ARFC_CTRL_IEN_BIT    6
`define ARFC_CLK_DIV_MSB     7
`define ARFC_CLK_DIV_LSB     5
`define ARFC_CLK_SRC_BIT     4
`define ARFC_CLK_FMT_MSB     3
`define ARFC_CLK_FMT_LSB     2
`define ARFC_IRQ_DONE_BIT    0
`define ARFC_IRQ_LOST_BIT    1
`define ARFC_IRQ_W           2

// ----------------------------------------------------------------------------
// Reset values and rates
// ----------------------------------------------------------------------------
`define ARFC_CLK_FMT_RST     8'h04
`define ARFC_CLK_MHZ         100
`define ARFC_CONV_CLK_MHZ    1

`endif

// ### core/arfc_pkg.sv
// Types shared by the result formatter and its testbench
`default_nettype none
package arfc_pkg;
    // Result justification formats, codes as held in the format field
    typedef enum logic [1:0] {
        ARFC_FMT_TRUNC8 = 2'h0,
        ARFC_FMT_RIGHT  = 2'h1,
        ARFC_FMT_LEFT   = 2'h2,
        ARFC_FMT_SIGNED = 2'h3
    } arfc_fmt_t;
endpackage
`default_nettype wire

// ### core/arfc_top.sv
// Converter result formatter, byte interlock, clock divider and register file
`timescale 1ns/10ps
`default_nettype none
`include "arfc_regs.svh"

// Behaviour
// - Left format: bits 9..2 high, 1..0 low top
// - Right format: bits 9..8 high low, 7..0 low
// - Signed left: like left, top bit inverted
// - Truncation: bits 9..2 in low, high zero
// - Load results on each conversion completion outside the interlock
// - High read freezes low until low read
// - Discard new results until pair read
// - Truncation mode has no low-byte interlock
// - Format codes: trunc, right, left, signed left
// - Format resets to right justified
// - Prescaler divides by 1,2,4,8 or 16
// - Source bit: 1 bus, 0 crystal clock
// - Reset selects crystal clock source
// - Done flag set, cleared by result read
// - Interrupt set at end, cleared by read/write
module arfc_top (
    input  wire logic                    clock,          // System clock, 100 MHz
    input  wire logic                    reset_n,        // Asynchronous reset, active low
    input  wire logic [`ARFC_ADDR_W-1:0] addr,           // Register word address
    input  wire logic [7:0]              wr_data,        // Write data
    input  wire logic                    wr_en,          // Write strobe
    input  wire logic                    rd_en,          // Read strobe
    output logic      [7:0]              rd_data,        // Read data, cycle after strobe
    input  wire logic                    bus_clk_en,     // Bus clock rate enable
    input  wire logic                    xtal_clk_en,    // Crystal clock rate enable
    input  wire logic [9:0]              raw_result,     // Raw converter result
    input  wire logic                    conv_done,      // Completion strobe
    output logic                         conv_clk_en,    // Converter clock enable pulse
    output arfc_pkg::arfc_fmt_t          fmt_mode,       // Current justification format
    output logic                         irq             // Level interrupt request
);
    import arfc_pkg::*;

    // ------------------------------------------------------------------------
    // Reset synchroniser
    // ------------------------------------------------------------------------
    logic        rst_meta_ff;                            // First stage
    logic        rst_n_ff;                               // Released reset for the block

    // Release through two stages, assert at once
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            rst_meta_ff <= 1'b0;
            rst_n_ff    <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_n_ff    <= rst_meta_ff;
        end
    end

    // ------------------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------------------
    logic [2:0]  div_sel_ff;                             // Prescaler field
    logic        src_sel_ff;                             // Input clock source
    arfc_fmt_t   fmt_ff;                                 // Format field
    logic        irq_en_ff;                              // Converter interrupt enable
    logic        done_ff;                                // Conversion done flag
    logic        conv_irq_ff;                            // Pending converter request
    logic        lock_ff;                                // Low byte frozen
    logic [7:0]  res_hi_ff;                              // High result byte
    logic [7:0]  res_lo_ff;                              // Low result byte
    logic [`ARFC_IRQ_W-1:0] ist_ff;                      // Sticky event status
    logic [`ARFC_IRQ_W-1:0] ien_ff;                      // Event enables
    logic [7:0]  rd_data_ff;                             // Read data register
    logic [3:0]  div_cnt_ff;                             // Prescaler counter
    logic        conv_clk_ff;                            // Divided clock pulse

    // ------------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------------
    wire         wr_ctrl  = wr_en && (addr == `ARFC_OFS_CONV_CTRL);  // Control write
    wire         wr_clk   = wr_en && (addr == `ARFC_OFS_CLK_FMT);    // Clock/format write
    wire         wr_iclr  = wr_en && (addr == `ARFC_OFS_IRQ_CLR);    // Status clear
    wire         wr_ien   = wr_en && (addr == `ARFC_OFS_IRQ_EN);     // Enable write
    wire         rd_hi    = rd_en && (addr == `ARFC_OFS_RES_HIGH);   // High byte read
    wire         rd_lo    = rd_en && (addr == `ARFC_OFS_RES_LOW);    // Low byte read
    wire         rd_res   = rd_hi || rd_lo;                          // Any result read

    // ------------------------------------------------------------------------
    // Result formatting
    // ------------------------------------------------------------------------
    wire         is_trunc = (fmt_ff == ARFC_FMT_TRUNC8);             // No interlock mode
    wire         set_lock = rd_hi && !is_trunc;                      // High read locks
    // A result arriving with the lock held, or in the lock cycle, is lost
    wire         blocked  = !is_trunc && (lock_ff || set_lock);
    wire         load     = conv_done && !blocked;
    wire         lost     = conv_done && blocked;                    // Dropped result event

    logic [7:0]  nxt_hi;                                 // Formatted high byte
    logic [7:0]  nxt_lo;                                 // Formatted low byte

    // Place the raw result as the current format asks
    always_comb begin
        case (fmt_ff)
            ARFC_FMT_TRUNC8: begin
                nxt_hi = 8'h00;
                nxt_lo = raw_result[9:2];
            end
            ARFC_FMT_RIGHT: begin
                nxt_hi = {6'h00, raw_result[9:8]};
                nxt_lo = raw_result[7:0];
            end
            ARFC_FMT_LEFT: begin
                nxt_hi = raw_result[9:2];
                nxt_lo = {raw_result[1:0], 6'h00};
            end
            ARFC_FMT_SIGNED: begin
                nxt_hi = {~raw_result[9], raw_result[8:2]};
                nxt_lo = {raw_result[1:0], 6'h00};
            end
            default: begin
                nxt_hi = 8'h00;
                nxt_lo = 8'h00;
            end
        endcase
    end

    // Result bytes hold between loads
    always_ff @(posedge clock or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            res_hi_ff <= 8'h00;
            res_lo_ff <= 8'h00;
        end else if (load) begin
            res_hi_ff <= nxt_hi;
            res_lo_ff <= nxt_lo;
        end
    end

    // Interlock: set by high read, freed by low read or truncation mode
    always_ff @(posedge clock or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            lock_ff <= 1'b0;
        end else if (set_lock) begin
            lock_ff <= 1'b1;
        end else if (rd_lo || is_trunc) begin
            lock_ff <= 1'b0;
        end
    end

    // ------------------------------------------------------------------------
    // Control register and completion flag
    // ------------------------------------------------------------------------
    wire         set_done = conv_done && !irq_en_ff;                 // Polled completion
    wire         set_cirq = conv_done && irq_en_ff;                  // Interrupt completion

    // Enable bit, written through the control register
    always_ff @(posedge clock or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            irq_en_ff <= 1'b0;
        end else if (wr_ctrl) begin
            irq_en_ff <= wr_data[`ARFC_CTRL_IEN_BIT];
        end
    end

    // Done flag: a new completion beats a result read in the same cycle
    always_ff @(posedge clock or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            done_ff <= 1'b0;
        end else if (set_done) begin
            done_ff <= 1'b1;
        end else if (rd_res || irq_en_ff) begin
            done_ff <= 1'b0;
        end
    end

    // Converter request: cleared by result read or control write, set wins
    always_ff @(posedge clock or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            conv_irq_ff <= 1'b0;
        end else if (set_cirq) begin
            conv_irq_ff <= 1'b1;
        end else if (rd_res || wr_ctrl) begin
            conv_irq_ff <= 1'b0;
        end
    end

    // ------------------------------------------------------------------------
    // Clock and format register
    // ------------------------------------------------------------------------
    localparam logic [7:0] CLK_FMT_RST = `ARFC_CLK_FMT_RST;         // Reset image

    // Prescaler, source and format fields
    always_ff @(posedge clock or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            div_sel_ff <= CLK_FMT_RST[`ARFC_CLK_DIV_MSB:`ARFC_CLK_DIV_LSB];
            src_sel_ff <= CLK_FMT_RST[`ARFC_CLK_SRC_BIT];
            fmt_ff     <= arfc_fmt_t'(CLK_FMT_RST[`ARFC_CLK_FMT_MSB:`ARFC_CLK_FMT_LSB]);
        end else if (wr_clk) begin
            div_sel_ff <= wr_data[`ARFC_CLK_DIV_MSB:`ARFC_CLK_DIV_LSB];
            src_sel_ff <= wr_data[`ARFC_CLK_SRC_BIT];
            fmt_ff     <= arfc_fmt_t'(wr_data[`ARFC_CLK_FMT_MSB:`ARFC_CLK_FMT_LSB]);
        end
    end

    // ------------------------------------------------------------------------
    // Converter clock divider
    // ------------------------------------------------------------------------
    // Chosen source rate, as a one-cycle enable
    wire         src_pulse = src_sel_ff ? bus_clk_en : xtal_clk_en;
    // Terminal count for the power-of-two divide; top bit set means 16
    wire [3:0]   div_last  = div_sel_ff[2]        ? 4'hF :
                             (div_sel_ff == 3'h3) ? 4'h7 :
                             (div_sel_ff == 3'h2) ? 4'h3 :
                             (div_sel_ff == 3'h1) ? 4'h1 : 4'h0;
    // A smaller divide written mid-count must still wrap
    wire         div_wrap  = src_pulse && (div_cnt_ff >= div_last);

    // Count source pulses, emit one pulse per wrap
    always_ff @(posedge clock or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            div_cnt_ff  <= 4'h0;
            conv_clk_ff <= 1'b0;
        end else begin
            conv_clk_ff <= div_wrap;
            if (div_wrap) begin
                div_cnt_ff <= 4'h0;
            end else if (src_pulse) begin
                div_cnt_ff <= div_cnt_ff + 4'h1;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Event status and interrupt
    // ------------------------------------------------------------------------
    wire [`ARFC_IRQ_W-1:0] ev_set = {lost, conv_done};               // Events, lost above done

    // One sticky bit per event; a set beats a clear in the same cycle
    genvar gi;
    generate
        for (gi = 0; gi < `ARFC_IRQ_W; gi = gi + 1) begin : g_ev
            always_ff @(posedge clock or negedge rst_n_ff) begin
                if (!rst_n_ff) begin
                    ist_ff[gi] <= 1'b0;
                end else if (ev_set[gi]) begin
                    ist_ff[gi] <= 1'b1;
                end else if (wr_iclr && wr_data[gi]) begin
                    ist_ff[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    // Event enables
    always_ff @(posedge clock or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            ien_ff <= '0;
        end else if (wr_ien) begin
            ien_ff <= wr_data[`ARFC_IRQ_W-1:0];
        end
    end

    // ------------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------------
    wire [7:0]   ctrl_rd = {done_ff, irq_en_ff, 6'h00};              // Control image
    wire [7:0]   clk_rd  = {div_sel_ff, src_sel_ff, fmt_ff, 2'h0};   // Clock/format image
    wire [7:0]   rd_mux  =
        (addr == `ARFC_OFS_CONV_CTRL) ? ctrl_rd :
        (addr == `ARFC_OFS_RES_HIGH)  ? res_hi_ff :
        (addr == `ARFC_OFS_RES_LOW)   ? res_lo_ff :
        (addr == `ARFC_OFS_CLK_FMT)   ? clk_rd :
        (addr == `ARFC_OFS_IRQ_STAT)  ? {6'h00, ist_ff} :
        (addr == `ARFC_OFS_IRQ_EN)    ? {6'h00, ien_ff} : 8'h00;     // Unmapped and clear read zero

    // Data stand only in the cycle after the strobe
    always_ff @(posedge clock or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            rd_data_ff <= 8'h00;
        end else begin
            rd_data_ff <= rd_en ? rd_mux : 8'h00;
        end
    end

    // ------------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------------
    assign rd_data     = rd_data_ff;
    assign conv_clk_en = conv_clk_ff;
    assign fmt_mode    = fmt_ff;
    assign irq         = conv_irq_ff || (|(ist_ff & ien_ff));

    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    AST_LEFT_FMT: assert property (@(posedge clock) disable iff (!rst_n_ff)
        load && fmt_ff == ARFC_FMT_LEFT |=>
            res_hi_ff == $past(raw_result[9:2]) && res_lo_ff == {$past(raw_result[1:0]), 6'h00})
        else $error("Left justified result misplaced");

    AST_RIGHT_FMT: assert property (@(posedge clock) disable iff (!rst_n_ff)
        load && fmt_ff == ARFC_FMT_RIGHT |=>
            res_hi_ff == {6'h00, $past(raw_result[9:8])} && res_lo_ff == $past(raw_result[7:0]))
        else $error("Right justified result misplaced");

    AST_SIGNED_FMT: assert property (@(posedge clock) disable iff (!rst_n_ff)
        load && fmt_ff == ARFC_FMT_SIGNED |=>
            res_hi_ff == {!$past(raw_result[9]), $past(raw_result[8:2])})
        else $error("Signed result top bit not inverted");

    AST_TRUNC_FMT: assert property (@(posedge clock) disable iff (!rst_n_ff)
        conv_done && is_trunc |=> res_hi_ff == 8'h00 && res_lo_ff == $past(raw_result[9:2]))
        else $error("Truncated result misplaced or not loaded");

    AST_LOW_FROZEN: assert property (@(posedge clock) disable iff (!rst_n_ff)
        rd_hi && !is_trunc ##1 (!rd_lo && !wr_clk) [*3] |=> $stable(res_lo_ff) && lock_ff)
        else $error("Low byte changed while frozen");

    AST_DISCARD: assert property (@(posedge clock) disable iff (!rst_n_ff)
        conv_done && lock_ff && !is_trunc |=> $stable(res_hi_ff) && ist_ff[`ARFC_IRQ_LOST_BIT])
        else $error("Result taken during interlock");

    AST_FMT_RESET: assert property (@(posedge clock)
        $rose(rst_n_ff) |-> fmt_ff == ARFC_FMT_RIGHT && !src_sel_ff && div_sel_ff == 3'h0)
        else $error("Clock and format fields wrong after reset");

    AST_DIV_ONE: assert property (@(posedge clock) disable iff (!rst_n_ff)
        div_sel_ff == 3'h0 && !wr_clk |=> conv_clk_en == (src_sel_ff ? $past(bus_clk_en) : $past(xtal_clk_en)))
        else $error("Undivided clock does not follow selected source");

    AST_DIV_SPAN: assert property (@(posedge clock) disable iff (!rst_n_ff)
        src_pulse && div_sel_ff == 3'h1 && div_cnt_ff <= 4'h1 |=>
            conv_clk_en == $past(div_cnt_ff[0]) && div_cnt_ff == (conv_clk_en ? 4'h0 : 4'h1))
        else $error("Divide by two wrapped at wrong count");

    AST_DONE_FLAG: assert property (@(posedge clock) disable iff (!rst_n_ff)
        conv_done && !irq_en_ff && !wr_ctrl |=> done_ff ##1 (done_ff || $past(rd_res)))
        else $error("Done flag not set or cleared without read");

    AST_CONV_IRQ: assert property (@(posedge clock) disable iff (!rst_n_ff)
        conv_done && irq_en_ff |=> irq && !done_ff)
        else $error("Completion did not raise interrupt");

endmodule
`default_nettype wire

// ### testbench/test_adc_result_format_and_clock.sv
// Self-checking bench for the converter result formatter, interlock, divider and interrupts
`timescale 1ns/10ps
`default_nettype none
`include "arfc_regs.svh"

module test_adc_result_format_and_clock;
    import arfc_pkg::*;
    // ------------------------------------------------------------------------
    // Signals and counters
    // ------------------------------------------------------------------------
    logic                    clock;        // System clock, 10 ns period
    logic                    reset_n;      // Reset, active low
    logic [`ARFC_ADDR_W-1:0] addr;         // Register word address
    logic [7:0]              wr_data;      // Write data
    logic                    wr_en;        // Write strobe
    logic                    rd_en;        // Read strobe
    logic [7:0]              rd_data;      // Read data
    logic                    bus_clk_en;   // Bus rate pulse
    logic                    xtal_clk_en;  // Crystal rate pulse
    logic [9:0]              raw_result;   // Raw converter result
    logic                    conv_done;    // Completion strobe
    logic                    conv_clk_en;  // Divided clock pulse
    arfc_fmt_t               fmt_mode;     // Current format
    logic                    irq;          // Interrupt request
    int                      fails;        // Mismatches seen
    int                      cmp_count;    // Comparisons made
    logic [15:0]             exp;          // Expected byte pair
    int                      cnt;          // Divider pulse count

    arfc_top DUT (.clock(clock), .reset_n(reset_n), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
                  .rd_en(rd_en), .rd_data(rd_data), .bus_clk_en(bus_clk_en), .xtal_clk_en(xtal_clk_en),
                  .raw_result(raw_result), .conv_done(conv_done), .conv_clk_en(conv_clk_en),
                  .fmt_mode(fmt_mode), .irq(irq));

    // Free-running clock
    always #5 clock = ~clock;

    // ------------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------------
    // Compare and count
    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        cmp_count++;
        if (seen !== want) begin
            fails++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask
    // One-cycle register write
    task automatic reg_wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clock);
        addr    <= a;
        wr_data <= d;
        wr_en   <= 1'b1;
        @(posedge clock);
        wr_en   <= 1'b0;
    endtask
    // Read, data taken in the cycle after the strobe
    task automatic reg_chk(input logic [2:0] a, input logic [7:0] want);
        @(posedge clock);
        addr  <= a;
        rd_en <= 1'b1;
        @(posedge clock);
        rd_en <= 1'b0;
        #1;
        check(rd_data, want);
    endtask
    // One completion strobe with a raw result
    task automatic conv(input logic [9:0] r);
        @(posedge clock);
        raw_result <= r;
        conv_done  <= 1'b1;
        @(posedge clock);
        conv_done  <= 1'b0;
        #1;
    endtask
    // Interrupt level after the updates have settled
    task automatic irq_chk(input logic want);
        @(posedge clock);
        #1;
        check({7'h00, irq}, {7'h00, want});
    endtask
    // Source pulses every cycle, then idle cycles to flush the last output
    task automatic div_run(input logic b, input logic x, input int n, output int c);
        c = 0;
        for (int i = 0; i < n + 3; i++) begin
            @(posedge clock);
            bus_clk_en  <= (i < n) ? b : 1'b0;
            xtal_clk_en <= (i < n) ? x : 1'b0;
            #1;
            if (conv_clk_en === 1'b1) c++;
        end
    endtask
    // Expected bytes {high, low} per format code
    function automatic logic [15:0] fmt_bytes(input logic [1:0] f, input logic [9:0] r);
        case (f)
            2'h0:    fmt_bytes = {8'h00, r[9:2]};
            2'h1:    fmt_bytes = {6'h00, r[9:8], r[7:0]};
            2'h2:    fmt_bytes = {r[9:2], r[1:0], 6'h00};
            default: fmt_bytes = {~r[9], r[8:2], r[1:0], 6'h00};
        endcase
    endfunction
    // Verdict and end of run
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Hang guard
    initial begin
        #500000;
        fails++;
        print_verdict();
    end

    // ------------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------------
    initial begin
        clock = 1'b0; reset_n = 1'b0; addr = 3'h0; wr_data = 8'h00; wr_en = 1'b0; rd_en = 1'b0;
        bus_clk_en = 1'b0; xtal_clk_en = 1'b0; raw_result = 10'h000; conv_done = 1'b0;
        fails = 0; cmp_count = 0;
        repeat (3) @(posedge clock);
        reset_n <= 1'b1;
        repeat (3) @(posedge clock);
        // Reset values and refused places
        check({6'h00, fmt_mode}, 8'h01);
        reg_chk(`ARFC_OFS_CLK_FMT, `ARFC_CLK_FMT_RST);
        reg_chk(`ARFC_OFS_IRQ_EN, 8'h00);
        reg_chk(3'h7, 8'h00);
        reg_chk(`ARFC_OFS_IRQ_CLR, 8'h00);
        // Every format code with one result
        for (int f = 0; f < 4; f++) begin
            reg_wr(`ARFC_OFS_CLK_FMT, 8'(f << 2));
            @(posedge clock);
            check({6'h00, fmt_mode}, 8'(f));
            conv(10'h2D3);
            exp = fmt_bytes(2'(f), 10'h2D3);
            reg_chk(`ARFC_OFS_RES_HIGH, exp[15:8]);
            reg_chk(`ARFC_OFS_RES_LOW, exp[7:0]);
        end
        // Interlock in right format: second result lost
        reg_wr(`ARFC_OFS_CLK_FMT, 8'h04);
        reg_wr(`ARFC_OFS_IRQ_CLR, 8'h03);
        conv(10'h155);
        reg_chk(`ARFC_OFS_RES_HIGH, 8'h01);
        conv(10'h2AA);
        reg_chk(`ARFC_OFS_RES_LOW, 8'h55);
        reg_chk(`ARFC_OFS_RES_HIGH, 8'h01);
        reg_chk(`ARFC_OFS_RES_LOW, 8'h55);
        reg_chk(`ARFC_OFS_IRQ_STAT, 8'h03);
        // Lost-result event alone raises the line when enabled
        reg_wr(`ARFC_OFS_IRQ_EN, 8'h02);
        irq_chk(1'b1);
        reg_wr(`ARFC_OFS_IRQ_CLR, 8'h02);
        irq_chk(1'b0);
        reg_wr(`ARFC_OFS_IRQ_EN, 8'h00);
        conv(10'h2AA);
        reg_chk(`ARFC_OFS_RES_HIGH, 8'h02);
        reg_chk(`ARFC_OFS_RES_LOW, 8'hAA);
        // Truncation: no lock on the low byte
        reg_wr(`ARFC_OFS_CLK_FMT, 8'h00);
        conv(10'h155);
        reg_chk(`ARFC_OFS_RES_HIGH, 8'h00);
        conv(10'h2AA);
        reg_chk(`ARFC_OFS_RES_LOW, 8'hAA);
        // Status interrupt raised, cleared, masked
        reg_wr(`ARFC_OFS_IRQ_CLR, 8'h03);
        reg_wr(`ARFC_OFS_IRQ_EN, 8'h01);
        reg_chk(`ARFC_OFS_IRQ_EN, 8'h01);
        conv(10'h100);
        irq_chk(1'b1);
        reg_chk(`ARFC_OFS_IRQ_STAT, 8'h01);
        reg_wr(`ARFC_OFS_IRQ_CLR, 8'h01);
        irq_chk(1'b0);
        reg_wr(`ARFC_OFS_IRQ_EN, 8'h00);
        conv(10'h100);
        irq_chk(1'b0);
        reg_chk(`ARFC_OFS_IRQ_STAT, 8'h01);
        // Done flag set by conversion, cleared by result read
        reg_chk(`ARFC_OFS_CONV_CTRL, 8'h80);
        reg_chk(`ARFC_OFS_RES_LOW, 8'h40);
        reg_chk(`ARFC_OFS_CONV_CTRL, 8'h00);
        // Converter request: cleared by result read and by control write
        reg_wr(`ARFC_OFS_CONV_CTRL, 8'h40);
        conv(10'h100);
        irq_chk(1'b1);
        reg_chk(`ARFC_OFS_CONV_CTRL, 8'h40);
        reg_chk(`ARFC_OFS_RES_LOW, 8'h40);
        irq_chk(1'b0);
        conv(10'h100);
        irq_chk(1'b1);
        reg_wr(`ARFC_OFS_CONV_CTRL, 8'h40);
        irq_chk(1'b0);
        reg_wr(`ARFC_OFS_CONV_CTRL, 8'h00);
        // Divider on crystal source, every prescaler code
        for (int d = 0; d < 8; d++) begin
            reg_wr(`ARFC_OFS_CLK_FMT, 8'((d << 5) | 4));
            reg_chk(`ARFC_OFS_CLK_FMT, 8'((d << 5) | 4));
            div_run(1'b0, 1'b1, 16, cnt);
            div_run(1'b1, 1'b1, 32, cnt);
            check(8'(cnt), 8'(32 / ((d >= 4) ? 16 : (1 << d))));
        end
        // Bus source at divide by two counted, crystal pulses ignored
        reg_wr(`ARFC_OFS_CLK_FMT, 8'h34);
        div_run(1'b1, 1'b0, 16, cnt);
        div_run(1'b1, 1'b0, 32, cnt);
        check(8'(cnt), 8'h10);
        div_run(1'b0, 1'b1, 32, cnt);
        check(8'(cnt), 8'h00);
        // Crystal pulse every 6 cycles, divide by 16: converter clock near 1 MHz
        reg_wr(`ARFC_OFS_CLK_FMT, 8'h84);
        cnt = 0;
        for (int i = 0; i < 2 * `ARFC_CLK_MHZ / `ARFC_CONV_CLK_MHZ; i++) begin
            @(posedge clock);
            xtal_clk_en <= (i % 6 == 0);
            #1;
            if (conv_clk_en === 1'b1) cnt++;
        end
        check(8'(cnt), 8'(2 * `ARFC_CONV_CLK_MHZ));
        print_verdict();
    end
endmodule
`default_nettype wire
